/* File: fbs_boot_select.sv */
// Flash boot select and code protection top level.
// Assumes an Avalon-MM master on sys_clk and synchronous pin inputs.
`timescale 1ns/1ps
module fbs_boot_select (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Processor side
	input  wire logic        cpu_idle_enter,
	input  wire logic        cpu_update_done,
	output logic             cpu_restart,
	output logic             cpu_resume,
	output logic             fetch_loader,
	output logic             upd_enable,
	output logic             upd_bank,
	output logic             upd_loader,
	// Reset pin and strap pins
	input  wire logic        rst_pin,
	input  wire logic        port2_bit6_strap,
	input  wire logic        port2_bit7_strap,
	input  wire logic        port4_bit3_strap,
	// External programmer
	input  wire logic        prog_mode,
	input  wire logic        prog_sec_wr,
	input  wire logic [7:0]  prog_sec_wdata,
	input  wire logic        prog_erase_all,
	output logic      [7:0]  prog_sec_rdata,
	output logic             prog_access_ok,
	// Code table read
	input  wire logic        tbl_exec_internal,
	input  wire logic        tbl_target_internal,
	output logic             tbl_internal_ok
);

	logic [7:0]           sec_bits;
	logic                 ack_q;
	logic                 ack_d;
	logic [31:0]          rdata_q;
	logic [31:0]          rdata_d;
	logic                 wr_go;
	logic [7:0]           ctrl_q;
	logic [7:0]           ctrl_d;
	logic [1:0]           bank_q;
	logic [1:0]           bank_d;
	fbs_pkg::fbs_state_t  state_q;
	fbs_pkg::fbs_state_t  state_d;
	logic                 loader_q;
	logic                 loader_d;
	logic                 restart_q;
	logic                 restart_d;
	logic                 resume_q;
	logic                 resume_d;
	logic                 pin_q;
	logic                 pin_d;
	logic                 reboot_q;
	logic                 reboot_d;
	logic                 strap_hit;

	////////////////////////////////////////////////////////////////////
	// Submodules
	fbs_sec_opt u_sec (
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.prog_mode      (prog_mode),
		.prog_sec_wr    (prog_sec_wr),
		.prog_sec_wdata (prog_sec_wdata),
		.prog_erase_all (prog_erase_all),
		.prog_sec_rdata (prog_sec_rdata),
		.prog_access_ok (prog_access_ok),
		.sec_bits       (sec_bits)
	);

	fbs_tbl_guard u_tbl (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.inhibit_bit         (sec_bits[fbs_pkg::SEC_INH_BIT]),
		.tbl_exec_internal   (tbl_exec_internal),
		.tbl_target_internal (tbl_target_internal),
		.tbl_internal_ok     (tbl_internal_ok)
	);

	////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, answer in the second
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign wr_go           = avs_write & ack_q;

	always_comb begin
		ack_d   = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		if (avs_read && !ack_q) begin
			unique case (avs_address)
				fbs_pkg::ADDR_CTRL:   rdata_d = {24'h000000, ctrl_q};
				fbs_pkg::ADDR_BANK:   rdata_d = {30'h00000000, bank_q};
				fbs_pkg::ADDR_STATUS: begin
					rdata_d = 32'h00000000;
					rdata_d[fbs_pkg::ST_LOADER_BIT] = loader_q;
					rdata_d[fbs_pkg::ST_UPDATE_BIT] = (state_q == fbs_pkg::FBS_UPDATE);
					rdata_d[fbs_pkg::ST_REBOOT_BIT] = reboot_q;
					rdata_d[fbs_pkg::ST_LOCK_BIT]   = ~sec_bits[fbs_pkg::SEC_LOCK_BIT];
				end
				default:              rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Strap capture while the reset pin is high
	assign strap_hit =
		(!sec_bits[fbs_pkg::SEC_RB_P2_BIT] && !port2_bit6_strap && !port2_bit7_strap)
		|| (!sec_bits[fbs_pkg::SEC_RB_P4_BIT] && !port4_bit3_strap);

	always_comb begin
		pin_d    = rst_pin;
		reboot_d = rst_pin ? strap_hit : reboot_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_q    <= 1'b0;
			reboot_q <= 1'b0;
		end else begin
			pin_q    <= pin_d;
			reboot_q <= reboot_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Region select, update state and registers
	assign fetch_loader = loader_q;
	assign cpu_restart  = restart_q;
	assign cpu_resume   = resume_q;
	assign upd_enable   = loader_q | (state_q == fbs_pkg::FBS_UPDATE);
	assign upd_bank     = bank_q[fbs_pkg::BANK_BIT];
	// Loader region is only a target while running the application
	assign upd_loader   = ~loader_q & bank_q[fbs_pkg::TARGET_BIT];

	always_comb begin
		ctrl_d    = ctrl_q;
		bank_d    = bank_q;
		state_d   = state_q;
		loader_d  = loader_q;
		restart_d = 1'b0;
		resume_d  = 1'b0;
		if (wr_go && avs_address == fbs_pkg::ADDR_CTRL) begin
			ctrl_d = avs_writedata[7:0];
		end
		// Bank is steered only where an update is possible
		if (wr_go && avs_address == fbs_pkg::ADDR_BANK && upd_enable) begin
			bank_d = avs_writedata[1:0];
		end
		if (pin_q) begin
			// Pin still high: hold in reset, pick region on release
			state_d  = fbs_pkg::FBS_RUN;
			ctrl_d   = fbs_pkg::CTRL_RESET;
			bank_d   = fbs_pkg::BANK_RESET;
			if (!rst_pin) begin
				loader_d = reboot_q;
			end
		end else if (wr_go && avs_address == fbs_pkg::ADDR_CTRL
				&& avs_writedata[7:0] == fbs_pkg::CMD_SW_RESTART) begin
			// Restart wins over any idle request in the same cycle
			loader_d  = 1'b0;
			restart_d = 1'b1;
			state_d   = fbs_pkg::FBS_RUN;
			ctrl_d    = fbs_pkg::CTRL_RESET;
			bank_d    = fbs_pkg::BANK_RESET;
		end else begin
			unique case (state_q)
				fbs_pkg::FBS_RUN: begin
					if (cpu_idle_enter && ctrl_q == fbs_pkg::CMD_LOADER_IDLE) begin
						loader_d  = 1'b1;
						restart_d = 1'b1;
					end else if (cpu_idle_enter && ctrl_q == fbs_pkg::CMD_APP_UPDATE
							&& !loader_q) begin
						state_d = fbs_pkg::FBS_UPDATE;
					end
				end
				fbs_pkg::FBS_UPDATE: begin
					if (cpu_update_done) begin
						state_d  = fbs_pkg::FBS_RUN;
						resume_d = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_q    <= fbs_pkg::CTRL_RESET;
			bank_q    <= fbs_pkg::BANK_RESET;
			state_q   <= fbs_pkg::FBS_RUN;
			loader_q  <= 1'b0;
			restart_q <= 1'b0;
			resume_q  <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			bank_q    <= bank_d;
			state_q   <= state_d;
			loader_q  <= loader_d;
			restart_q <= restart_d;
			resume_q  <= resume_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_idle_loader;
		!pin_q && state_q == fbs_pkg::FBS_RUN && cpu_idle_enter
			&& ctrl_q == fbs_pkg::CMD_LOADER_IDLE
			&& !(wr_go && avs_address == fbs_pkg::ADDR_CTRL);
	endsequence

	sequence s_idle_update;
		!pin_q && state_q == fbs_pkg::FBS_RUN && !loader_q && cpu_idle_enter
			&& ctrl_q == fbs_pkg::CMD_APP_UPDATE
			&& !(wr_go && avs_address == fbs_pkg::ADDR_CTRL);
	endsequence

	sequence s_sw_restart;
		!pin_q && wr_go && avs_address == fbs_pkg::ADDR_CTRL
			&& avs_writedata[7:0] == fbs_pkg::CMD_SW_RESTART;
	endsequence

	chk_idle_loader: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_idle_loader |=> fetch_loader && cpu_restart)
		else $error("idle with 03h did not enter loader with reset");
	chk_sw_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_sw_restart |=> !fetch_loader && cpu_restart ##1 !cpu_restart)
		else $error("83h write did not restart into application");
	chk_app_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_idle_update |=> !fetch_loader && !cpu_restart && upd_enable)
		else $error("idle with 01h did not enter in-place update");
	chk_update_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == fbs_pkg::FBS_UPDATE && cpu_update_done && !pin_q
			&& !(wr_go && avs_address == fbs_pkg::ADDR_CTRL))
		|=> cpu_resume && !cpu_restart && !fetch_loader)
		else $error("update did not resume without reset");
	chk_bank_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!pin_q && wr_go && avs_address == fbs_pkg::ADDR_BANK && fetch_loader)
		|=> upd_bank == $past(avs_writedata[0]))
		else $error("loader bank select write not applied");
	chk_reboot_p2: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rst_pin && !sec_bits[fbs_pkg::SEC_RB_P2_BIT] && !port2_bit6_strap && !port2_bit7_strap)
		##1 (pin_q && !rst_pin) |=> fetch_loader)
		else $error("port2 strap reboot did not select loader");
	chk_reboot_p4: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rst_pin && !sec_bits[fbs_pkg::SEC_RB_P4_BIT] && !port4_bit3_strap)
		##1 (pin_q && !rst_pin) |=> fetch_loader)
		else $error("port4 strap reboot did not select loader");
	chk_default_app: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rst_pin && !strap_hit) ##1 (pin_q && !rst_pin) |=> !fetch_loader)
		else $error("plain reset did not boot the application");
	chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer later than one wait cycle");

endmodule

/* File: fbs_pkg.sv */
// Shared constants and types for the flash boot select block.
// Assumes a single core clock and a synchronous active-low reset.
package fbs_pkg;

	////////////////////////////////////////////////////////////////////
	// Register word indices on the Avalon slave
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_BANK   = 2'h1;
	localparam logic [1:0] ADDR_STATUS = 2'h2;

	////////////////////////////////////////////////////////////////////
	// Control register commands and reset values
	localparam logic [7:0] CTRL_RESET      = 8'h00;
	localparam logic [7:0] CMD_LOADER_IDLE = 8'h03;
	localparam logic [7:0] CMD_APP_UPDATE  = 8'h01;
	localparam logic [7:0] CMD_SW_RESTART  = 8'h83;
	localparam logic [1:0] BANK_RESET      = 2'h0;

	// Bank select fields
	localparam int BANK_BIT   = 0;
	localparam int TARGET_BIT = 1;

	// Status fields
	localparam int ST_LOADER_BIT = 0;
	localparam int ST_UPDATE_BIT = 1;
	localparam int ST_REBOOT_BIT = 2;
	localparam int ST_LOCK_BIT   = 3;

	////////////////////////////////////////////////////////////////////
	// Security option register
	localparam logic [7:0] SEC_ERASED    = 8'hff;
	localparam int         SEC_LOCK_BIT  = 0;
	localparam int         SEC_INH_BIT   = 1;
	localparam int         SEC_RB_P2_BIT = 4;
	localparam int         SEC_RB_P4_BIT = 5;

	typedef enum logic [0:0] {
		FBS_RUN,
		FBS_UPDATE
	} fbs_state_t;

endpackage

/* File: fbs_sec_opt.sv */
// Security option register reached only by the external programmer.
// Assumes the programmer strobes are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module fbs_sec_opt (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       prog_mode,
	input  wire logic       prog_sec_wr,
	input  wire logic [7:0] prog_sec_wdata,
	input  wire logic       prog_erase_all,
	output logic      [7:0] prog_sec_rdata,
	output logic            prog_access_ok,
	output logic      [7:0] sec_bits
);

	logic [7:0] sec_q;
	logic [7:0] sec_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	////////////////////////////////////////////////////////////////////
	// Lock bit at zero shuts the programmer out of reads and writes; erase still works
	assign prog_access_ok = prog_mode & sec_q[fbs_pkg::SEC_LOCK_BIT];
	assign sec_bits       = sec_q;
	assign prog_sec_rdata = rdata_q;

	always_comb begin
		sec_d   = sec_q;
		rdata_d = prog_access_ok ? sec_q : 8'h00;
		if (prog_erase_all) begin
			sec_d = fbs_pkg::SEC_ERASED;
		end else if (prog_access_ok && prog_sec_wr) begin
			// Programming only pulls bits low
			sec_d = sec_q & prog_sec_wdata;
		end
	end

	// Stands in for the nonvolatile cells; reset shows the erased state
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sec_q   <= fbs_pkg::SEC_ERASED;
			rdata_q <= 8'h00;
		end else begin
			sec_q   <= sec_d;
			rdata_q <= rdata_d;
		end
	end

	chk_sec_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!prog_erase_all |=> (sec_q & ~$past(sec_q)) == 8'h00)
		else $error("security bit returned to one without erase");
	chk_sec_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!sec_q[fbs_pkg::SEC_LOCK_BIT] && !prog_erase_all) |=> $stable(sec_q) && rdata_q == 8'h00)
		else $error("locked security register was reached");
	chk_sec_erase: assert property (@(posedge sys_clk) disable iff (!rst_n)
		prog_erase_all |=> sec_q == fbs_pkg::SEC_ERASED)
		else $error("erase did not set all option bits");
	chk_sec_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!prog_mode && !prog_erase_all) |=> $stable(sec_q) && rdata_q == 8'h00)
		else $error("security register reached outside programming mode");

endmodule

/* File: fbs_tbl_guard.sv */
// Gate on code table reads that target internal flash.
// Assumes the core reports where the read executes and what it targets.
`timescale 1ns/1ps
module fbs_tbl_guard (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic inhibit_bit,
	input  wire logic tbl_exec_internal,
	input  wire logic tbl_target_internal,
	output logic      tbl_internal_ok
);

	////////////////////////////////////////////////////////////////////
	// External code may not peek at internal flash when inhibited
	assign tbl_internal_ok = tbl_target_internal
		& (tbl_exec_internal | inhibit_bit);

	chk_tbl_inhibit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!inhibit_bit && !tbl_exec_internal) |-> !tbl_internal_ok)
		else $error("external table read reached internal flash");
	chk_tbl_internal: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tbl_exec_internal |-> tbl_internal_ok == tbl_target_internal)
		else $error("internal table read was restricted");
	chk_tbl_free: assert property (@(posedge sys_clk) disable iff (!rst_n)
		inhibit_bit |-> tbl_internal_ok == tbl_target_internal)
		else $error("table read restricted with inhibit released");

endmodule

/* File: fbs_prog_model.sv */
// Behavioural external programmer on the security option port.
// Assumes strobes launch just after a rising sys_clk edge.
`timescale 1ns/1ps
module fbs_prog_model (
	input  wire logic       sys_clk,
	output logic            prog_mode,
	output logic            prog_sec_wr,
	output logic      [7:0] prog_sec_wdata,
	output logic            prog_erase_all
);
	initial begin
		prog_mode      = 1'b0;
		prog_sec_wr    = 1'b0;
		prog_sec_wdata = 8'h00;
		prog_erase_all = 1'b0;
	end
	////////////////////////////////////////////////////////////////////
	task automatic set_mode(input logic m);
		@(posedge sys_clk);
		prog_mode <= m;
	endtask
	// Data inverted after the strobe, nothing holds the lines
	task automatic write_sec(input logic [7:0] d);
		@(posedge sys_clk);
		prog_sec_wr    <= 1'b1;
		prog_sec_wdata <= d;
		@(posedge sys_clk);
		prog_sec_wr    <= 1'b0;
		prog_sec_wdata <= ~d;
	endtask
	task automatic erase_all();
		@(posedge sys_clk);
		prog_erase_all <= 1'b1;
		@(posedge sys_clk);
		prog_erase_all <= 1'b0;
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the flash boot select block.
// Assumes the programmer model drives the security port.
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  avs_address = 2'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cpu_idle_enter = 1'b0;
	logic        cpu_update_done = 1'b0;
	logic        cpu_restart, cpu_resume, fetch_loader, upd_enable, upd_bank, upd_loader;
	logic        rst_pin = 1'b0;
	logic        port2_bit6_strap = 1'b1;
	logic        port2_bit7_strap = 1'b1;
	logic        port4_bit3_strap = 1'b1;
	logic        prog_mode, prog_sec_wr, prog_erase_all, prog_access_ok;
	logic [7:0]  prog_sec_wdata, prog_sec_rdata;
	logic        tbl_exec_internal = 1'b0;
	logic        tbl_target_internal = 1'b0;
	logic        tbl_internal_ok;
	logic [31:0] rd;
	logic [7:0]  m_sec = 8'hff;
	logic        pm = 1'b0;
	logic        b;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;

	always #5 sys_clk = ~sys_clk;

	fbs_boot_select DUT (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .cpu_idle_enter, .cpu_update_done, .cpu_restart,
		.cpu_resume, .fetch_loader, .upd_enable, .upd_bank, .upd_loader, .rst_pin,
		.port2_bit6_strap, .port2_bit7_strap, .port4_bit3_strap, .prog_mode, .prog_sec_wr,
		.prog_sec_wdata, .prog_erase_all, .prog_sec_rdata, .prog_access_ok,
		.tbl_exec_internal, .tbl_target_internal, .tbl_internal_ok);
	fbs_prog_model u_prog (.sys_clk, .prog_mode, .prog_sec_wr, .prog_sec_wdata, .prog_erase_all);

	////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		#1;
	endtask
	task automatic pulse(input logic done);
		@(posedge sys_clk);
		if (done) cpu_update_done <= 1'b1; else cpu_idle_enter <= 1'b1;
		@(posedge sys_clk);
		cpu_update_done <= 1'b0;
		cpu_idle_enter  <= 1'b0;
		#1;
	endtask
	// Model of the option bits: only ever cleared by a permitted write
	task automatic psec(input logic [7:0] d);
		u_prog.write_sec(d);
		if (pm && m_sec[0]) m_sec = m_sec & d;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(prog_access_ok, pm & m_sec[0]);
		chk(prog_sec_rdata, (pm & m_sec[0]) ? m_sec : 8'h00);
	endtask
	task automatic erase();
		u_prog.erase_all();
		m_sec = 8'hff;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(prog_sec_rdata, pm ? 8'hff : 8'h00);
	endtask
	// Straps driven while the reset pin is high and for four cycles after its release, pull-ups otherwise
	task automatic reboot(input logic p6, input logic p7, input logic p3);
		logic e;
		e = (!m_sec[4] && !p6 && !p7) || (!m_sec[5] && !p3);
		@(posedge sys_clk);
		rst_pin          <= 1'b1;
		port2_bit6_strap <= p6;
		port2_bit7_strap <= p7;
		port4_bit3_strap <= p3;
		repeat (4) @(posedge sys_clk);
		rst_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
		{port2_bit6_strap, port2_bit7_strap, port4_bit3_strap} <= 3'h7;
		#1;
		chk(fetch_loader, e);
		av(1'b0, fbs_pkg::ADDR_STATUS, 32'h0);
		chk(rd, {28'h0, ~m_sec[0], e, 1'b0, e});
		av(1'b1, fbs_pkg::ADDR_CTRL, {24'h0, fbs_pkg::CMD_SW_RESTART});
		chk(fetch_loader, 1'b0);
	endtask
	task automatic tbl();
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			tbl_exec_internal   <= i[0];
			tbl_target_internal <= i[1];
			#1;
			chk(tbl_internal_ok, i[1] & (i[0] | m_sec[1]));
		end
	endtask

	////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		void'($urandom(27748));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk(fetch_loader, 1'b0);
		av(1'b1, 2'h3, 32'hffff_ffff);
		av(1'b0, 2'h3, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
		// Loader switch, bank pick, software restart
		av(1'b1, fbs_pkg::ADDR_CTRL, {24'h0, fbs_pkg::CMD_LOADER_IDLE});
		pulse(1'b0);
		chk(cpu_restart, 1'b1);
		chk(fetch_loader, 1'b1);
		@(posedge sys_clk);
		#1;
		chk(cpu_restart, 1'b0);
		av(1'b0, fbs_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h1);
		b = 1'($urandom % 2);
		av(1'b1, fbs_pkg::ADDR_BANK, {31'h0, b});
		chk(upd_bank, b);
		chk(upd_enable, 1'b1);
		av(1'b1, fbs_pkg::ADDR_CTRL, {24'h0, fbs_pkg::CMD_SW_RESTART});
		chk(cpu_restart, 1'b1);
		chk(fetch_loader, 1'b0);
		$display("test loader done");
		// In-place update with resume
		av(1'b1, fbs_pkg::ADDR_CTRL, {24'h0, fbs_pkg::CMD_APP_UPDATE});
		pulse(1'b0);
		chk({cpu_restart, fetch_loader, upd_enable}, 3'h1);
		av(1'b1, fbs_pkg::ADDR_BANK, 32'h2);
		chk(upd_loader, 1'b1);
		pulse(1'b1);
		chk({cpu_resume, cpu_restart}, 2'h2);
		@(posedge sys_clk);
		#1;
		chk({cpu_resume, fetch_loader}, 2'h0);
		$display("test update done");
		// Programmer access, sticky bits, straps, table reads, lock
		psec(8'h00);
		u_prog.set_mode(1'b1);
		pm = 1'b1;
		psec(8'hef);
		psec(8'hff);
		reboot(1'b0, 1'b0, 1'b1);
		reboot(1'b0, 1'b1, 1'b0);
		erase();
		psec(8'hdf);
		reboot(1'b1, 1'b1, 1'b0);
		reboot(1'b0, 1'b0, 1'b1);
		erase();
		tbl();
		psec(8'hfd);
		tbl();
		psec(8'hfe);
		av(1'b0, fbs_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h8);
		psec(8'h00);
		erase();
		psec(8'hff);
		$display("test programmer done");
		summarize();
	end
endmodule
